// ==== verilog/scr_pkg.sv ====
// Shared constants and carrier types of the system-bus register responder
package scr_pkg;
  // Register offsets within the node's window (byte offsets, bits 6:0)
  localparam logic [6:0] OFF_DEV  = 7'h00; // device_type
  localparam logic [6:0] OFF_BER  = 7'h04; // bus_error
  localparam logic [6:0] OFF_FADR = 7'h08; // failing_address
  localparam logic [6:0] OFF_GPR  = 7'h0c; // general_purpose
  localparam logic [6:0] OFF_NCSR = 7'h1c; // node_control_status
  localparam logic [6:0] OFF_BCR  = 7'h24; // bus_control
  localparam logic [6:0] OFF_FAER = 7'h2c; // failing_address_extension
  localparam logic [6:0] OFF_BEER = 7'h34; // bus_error_extension
  localparam logic [6:0] OFF_WF0  = 7'h40; // writeback0_failing_address
  localparam logic [6:0] OFF_WF1  = 7'h44; // writeback1_failing_address
  // Window placement: each node owns one 512 KB window above the base
  localparam int unsigned NS_SHIFT       = 19;
  localparam logic [31:0] NODESPACE_BASE = 32'h2180_0000;
  // Field positions
  localparam int unsigned BER_WEI_BIT  = 27; // write_error_flag
  localparam int unsigned BER_ERR_BIT  = 31; // Summary of a logged bus error
  localparam int unsigned BCR_HEIE_BIT = 0;  // Hard error interrupt enable
  // Reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] RST_BCR  = 32'h0000_0001;
  // Identity word; the value is arbitrary
  localparam logic [31:0] DEV_TYPE_ID = 32'h0000_5a01;

  // Commands of a register reference
  typedef enum logic [1:0] {
    CMD_READ,
    CMD_IREAD,
    CMD_WMASK,
    CMD_UWMASK
  } scr_cmd_type;

  // Kind of transaction issued toward the bus
  typedef enum logic [1:0] {
    TX_NONE,
    TX_RSP,
    TX_WB,
    TX_CPU
  } scr_tx_type;

  // One register reference from a bus node or the local processor
  typedef struct packed {
    logic        valid;
    scr_cmd_type cmd;
    logic [31:0] addr;
    logic [3:0]  mask;
    logic [31:0] wdata;
  } scr_ref_type;

  // Implied-vector interrupt seen on the bus
  typedef struct packed {
    logic        valid;
    logic        write_err;
    logic [15:0] mask;
  } scr_ivi_type;

  // Error event from the commander side
  typedef struct packed {
    logic        valid;
    logic        wb;
    logic        queue;
    logic [31:0] addr;
    logic [31:0] addr_ext;
    logic [31:0] code;
  } scr_err_type;
endpackage : scr_pkg

// ==== verilog/scr_responder.sv ====
// Register responder of the system-bus interface: decode, side effects, response
// Summary of operation
// - Writes ignore byte mask, update full longword
// - Interlocked commands behave as plain ones
// - Negative acknowledge while a read is pending
// - Read-only writes acknowledged, nothing changes
// - Longword access only, full word returned
// - Only own node window is decoded
// - Separate failing address per writeback queue
// - Fixed register offsets from window base
// - Write-error interrupt sets flag, raises hard error
// - Priority: read response, writeback, processor
module scr_responder
(
  // Clock and reset
  input  wire logic                 SYS_CLK,
  input  wire logic                 RST_N,
  // Node identity pins
  input  wire logic [3:0]           NODE_ID,
  // Register reference and its acknowledge
  input  wire scr_pkg::scr_ref_type REF,
  output      logic                 REF_ACK,
  output      logic                 REF_NACK,
  // Error and interrupt events
  input  wire scr_pkg::scr_ivi_type IVI,
  input  wire scr_pkg::scr_err_type ERR,
  output      logic                 HARD_ERR_IRQ,
  // Pending outbound work
  input  wire logic [1:0]           WB_PEND,
  input  wire logic                 CPU_PEND,
  // Outbound transaction
  input  wire logic                 TX_READY,
  output      logic                 TX_VALID,
  output      scr_pkg::scr_tx_type  TX_KIND,
  output      logic [31:0]          TX_DATA
);

  logic [3:0]  node_meta;       // First stage of the pin synchroniser
  logic [3:0]  node_id;         // Synchronised node number
  logic        hit;             // Reference falls in this node's window
  logic [6:0]  off;             // Longword offset, byte bits dropped
  logic        listed_area;     // Inside the decoded 128-byte area
  logic        is_read;         // Read or interlocked read
  logic        take;            // Reference accepted this cycle
  logic        rd_pend;         // Single responder slot holds a read
  logic [31:0] rd_data_q;       // Data waiting to be returned
  logic [31:0] next_rd_data;    // Read mux result
  logic [31:0] bus_error;       // Error flags
  logic [31:0] failing_address; // Last failing address
  logic [31:0] general_purpose; // Scratch register
  logic [31:0] node_control_status;
  logic [31:0] bus_control;
  logic [31:0] failing_address_extension;
  logic [31:0] bus_error_extension;
  logic [31:0] wb_fail [2];     // Per-queue failing addresses
  logic        wei_hit;         // Write-error interrupt aimed at us
  logic        tx_done;         // Outbound handshake this cycle

  // Tag of this node's window in the upper address bits
  function automatic logic [12:0] ns_tag(input logic [3:0] id);
    ns_tag = 13'(scr_pkg::NODESPACE_BASE[31:scr_pkg::NS_SHIFT] + 13'(id));
  endfunction : ns_tag

  // Node pins cross two flops before use
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      node_meta <= 4'h0;
      node_id   <= 4'h0;
    end
    else
    begin
      node_meta <= NODE_ID;
      node_id   <= node_meta;
    end
  end

  // Decode; private space and other windows never match
  always_comb
  begin
    hit         = REF.valid && (REF.addr[31:scr_pkg::NS_SHIFT] == ns_tag(node_id));
    off         = {REF.addr[6:2], 2'b00};
    listed_area = (REF.addr[scr_pkg::NS_SHIFT-1:7] == '0);
    is_read     = (REF.cmd == scr_pkg::CMD_READ) || (REF.cmd == scr_pkg::CMD_IREAD);
    take        = hit && !rd_pend;
    wei_hit     = IVI.valid && IVI.write_err && IVI.mask[node_id];
    tx_done     = TX_VALID && TX_READY;
  end

  // Read mux over the full longwords
  always_comb
  begin
    next_rd_data = scr_pkg::RST_WORD;
    if (listed_area)
    begin
      case (off)
        scr_pkg::OFF_DEV:  next_rd_data = scr_pkg::DEV_TYPE_ID;
        scr_pkg::OFF_BER:  next_rd_data = bus_error;
        scr_pkg::OFF_FADR: next_rd_data = failing_address;
        scr_pkg::OFF_GPR:  next_rd_data = general_purpose;
        scr_pkg::OFF_NCSR: next_rd_data = node_control_status;
        scr_pkg::OFF_BCR:  next_rd_data = bus_control;
        scr_pkg::OFF_FAER: next_rd_data = failing_address_extension;
        scr_pkg::OFF_BEER: next_rd_data = bus_error_extension;
        scr_pkg::OFF_WF0:  next_rd_data = wb_fail[0];
        scr_pkg::OFF_WF1:  next_rd_data = wb_fail[1];
        default:           next_rd_data = scr_pkg::RST_WORD;
      endcase
    end
  end

  // Acknowledge; a busy slot refuses everything, the sender retries
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      REF_ACK  <= 1'b0;
      REF_NACK <= 1'b0;
    end
    else
    begin
      REF_ACK  <= take;
      REF_NACK <= hit && rd_pend;
    end
  end

  // Single responder slot: loaded by a read, freed when data goes out
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rd_pend   <= 1'b0;
      rd_data_q <= scr_pkg::RST_WORD;
    end
    else if (take && is_read)
    begin
      rd_pend   <= 1'b1;
      rd_data_q <= next_rd_data;
    end
    else if (tx_done && (TX_KIND == scr_pkg::TX_RSP))
      rd_pend <= 1'b0;
  end

  // Read-write registers take the whole word; mask is not looked at
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      general_purpose     <= scr_pkg::RST_WORD;
      node_control_status <= scr_pkg::RST_WORD;
      bus_control         <= scr_pkg::RST_BCR;
    end
    else if (take && !is_read && listed_area)
    begin
      if (off == scr_pkg::OFF_GPR)
        general_purpose <= REF.wdata;
      if (off == scr_pkg::OFF_NCSR)
        node_control_status <= REF.wdata;
      if (off == scr_pkg::OFF_BCR)
        bus_control <= REF.wdata;
    end
  end

  // Error flags: hardware sets, writing one clears, a set wins the tie
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      bus_error <= scr_pkg::RST_WORD;
    else
    begin
      if (take && !is_read && listed_area && (off == scr_pkg::OFF_BER))
        bus_error <= bus_error & ~REF.wdata;
      if (wei_hit)
        bus_error[scr_pkg::BER_WEI_BIT] <= 1'b1;
      if (ERR.valid)
        bus_error[scr_pkg::BER_ERR_BIT] <= 1'b1;
    end
  end

  // Failure capture; software writes here are acknowledged and dropped
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      failing_address           <= scr_pkg::RST_WORD;
      failing_address_extension <= scr_pkg::RST_WORD;
      bus_error_extension       <= scr_pkg::RST_WORD;
      wb_fail[0]                <= scr_pkg::RST_WORD;
      wb_fail[1]                <= scr_pkg::RST_WORD;
    end
    else if (ERR.valid)
    begin
      failing_address           <= ERR.addr;
      failing_address_extension <= ERR.addr_ext;
      bus_error_extension       <= ERR.code;
      if (ERR.wb)
        wb_fail[ERR.queue] <= ERR.addr;
    end
  end

  // Hard error line follows the flag when enabled
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
      HARD_ERR_IRQ <= 1'b0;
    else
      HARD_ERR_IRQ <= (bus_error[scr_pkg::BER_WEI_BIT] || wei_hit) && bus_control[scr_pkg::BCR_HEIE_BIT];
  end

  // Outbound arbiter: holds until taken, then idles one cycle
  always_ff @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      TX_VALID <= 1'b0;
      TX_KIND  <= scr_pkg::TX_NONE;
      TX_DATA  <= scr_pkg::RST_WORD;
    end
    else if (TX_VALID)
    begin
      if (TX_READY)
      begin
        TX_VALID <= 1'b0;
        TX_KIND  <= scr_pkg::TX_NONE;
      end
    end
    else if (rd_pend)
    begin
      TX_VALID <= 1'b1;
      TX_KIND  <= scr_pkg::TX_RSP;
      TX_DATA  <= rd_data_q;
    end
    else if (|WB_PEND)
    begin
      TX_VALID <= 1'b1;
      TX_KIND  <= scr_pkg::TX_WB;
    end
    else if (CPU_PEND)
    begin
      TX_VALID <= 1'b1;
      TX_KIND  <= scr_pkg::TX_CPU;
    end
  end

  // Checks
  sequence s_write_taken(logic [6:0] o);
    take && !is_read && listed_area && (off == o);
  endsequence

  sequence s_read_taken;
    take && is_read;
  endsequence

  AST_FULL_WORD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    s_write_taken(scr_pkg::OFF_GPR) |=> general_purpose == $past(REF.wdata))
    else $error("general purpose write not full word");

  AST_ILOCK_READ: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (take && REF.cmd == scr_pkg::CMD_IREAD) |=> rd_pend && REF_ACK)
    else $error("interlocked read not handled as read");

  AST_NACK_PEND: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (hit && rd_pend) |=> REF_NACK && !REF_ACK)
    else $error("reference not refused while read pending");

  AST_RO_WRITE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_write_taken(scr_pkg::OFF_FADR) and !ERR.valid) |=> REF_ACK && $stable(failing_address))
    else $error("read-only register changed by write");

  AST_READ_WORD: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_read_taken and (off == scr_pkg::OFF_GPR) and listed_area) |=> rd_data_q == $past(general_purpose))
    else $error("read did not capture full register");

  AST_FOREIGN: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (REF.valid && !hit) |=> !REF_ACK && !REF_NACK)
    else $error("foreign address answered");

  AST_WB_SPLIT: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (ERR.valid && ERR.wb && !ERR.queue) |=> wb_fail[0] == $past(ERR.addr) && $stable(wb_fail[1]))
    else $error("writeback queue failing address mixed up");

  AST_WEI: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (wei_hit && bus_control[scr_pkg::BCR_HEIE_BIT]) |=> bus_error[scr_pkg::BER_WEI_BIT] && HARD_ERR_IRQ)
    else $error("write error interrupt not flagged");

  AST_PRIO: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (!TX_VALID && rd_pend) |=> TX_VALID && TX_KIND == scr_pkg::TX_RSP)
    else $error("read response lost priority");

  AST_SLOT_FREE: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (tx_done && TX_KIND == scr_pkg::TX_RSP) |=> !rd_pend ##1 !TX_VALID || TX_KIND != scr_pkg::TX_RSP)
    else $error("slot not freed after response");

  AST_UNLISTED: assert property (@(posedge SYS_CLK) disable iff (!RST_N)
    (s_read_taken and !listed_area) |=> rd_data_q == scr_pkg::RST_WORD)
    else $error("unlisted offset read not zero");

endmodule : scr_responder

// ==== bench/scr_node_model.sv ====
// Model of the other bus nodes: register references and outbound acceptor
module scr_node_model
(
  // Clock
  input  wire logic                 SYS_CLK,
  // Reference toward the responder
  output      scr_pkg::scr_ref_type REF,
  input  wire logic                 REF_ACK,
  input  wire logic                 REF_NACK,
  // Outbound work sources and acceptor
  output      logic [1:0]           WB_PEND,
  output      logic                 CPU_PEND,
  output      logic                 TX_READY,
  input  wire logic                 TX_VALID,
  input  wire scr_pkg::scr_tx_type  TX_KIND,
  input  wire logic [31:0]          TX_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  int                  stall    = 0; // Cycles each outbound transfer is held off
  int                  wait_cnt = 0; // Stall progress
  int                  rsp_cnt  = 0; // Read responses taken
  logic [31:0]         last_rsp;     // Data of the latest read response
  scr_pkg::scr_tx_type kinds[$];     // Order of taken transfers

  // Idle outputs at time zero
  initial
  begin
    REF      = '0;
    WB_PEND  = 2'h0;
    CPU_PEND = 1'b0;
    TX_READY = 1'b0;
  end

  // One reference; a refused one is offered again later when retry is set
  task automatic xfer(input scr_pkg::scr_cmd_type c, input logic [31:0] a, input logic [31:0] d,
                      input bit retry, output logic ack, output logic nack);
    int tries;
    tries = 0;
    do
    begin
      @(posedge SYS_CLK);
      REF <= '{1'b1, c, a, 4'h0, d};
      @(posedge SYS_CLK);
      // Released lines show inverted data; only the command keeps its old value
      REF <= '{1'b0, c, ~a, 4'hf, ~d};
      @(posedge SYS_CLK);
      ack  = REF_ACK;
      nack = REF_NACK;
      tries++;
    end
    while (retry && nack && tries < 50);
  endtask : xfer

  // Accepts after the stall; a source drops its level at its handshake
  always @(posedge SYS_CLK)
  begin
    if (TX_VALID && TX_READY)
    begin
      // Ready is a one-cycle pulse, dropped right after the handshake
      TX_READY <= 1'b0;
      kinds.push_back(TX_KIND);
      if (TX_KIND == scr_pkg::TX_RSP)
      begin
        last_rsp <= TX_DATA;
        rsp_cnt  <= rsp_cnt + 1;
      end
      if (TX_KIND == scr_pkg::TX_WB)
        WB_PEND <= 2'h0;
      if (TX_KIND == scr_pkg::TX_CPU)
        CPU_PEND <= 1'b0;
    end
    else if (TX_VALID)
    begin
      // Slow bus: hold ready off for the programmed span
      if (wait_cnt >= stall)
      begin
        TX_READY <= 1'b1;
        wait_cnt <= 0;
      end
      else
        wait_cnt <= wait_cnt + 1;
    end
  end
endmodule : scr_node_model

// ==== bench/tb_top.sv ====
// Self-checking bench of the register responder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0]  NODE = 4'h2; // Own node number
  localparam logic [31:0] BASE = scr_pkg::NODESPACE_BASE + (32'(NODE) << scr_pkg::NS_SHIFT);
  logic                 sys_clk, rst_n, ref_ack, ref_nack, hard_err_irq;
  logic                 cpu_pend, tx_ready, tx_valid, ack, nack;
  logic [1:0]           wb_pend;
  logic [31:0]          tx_data, rdat;
  scr_pkg::scr_ref_type ref_bus;
  scr_pkg::scr_ivi_type ivi;
  scr_pkg::scr_err_type err;
  scr_pkg::scr_tx_type  tx_kind;
  int                   failures    = 0;
  int                   comparisons = 0;
  int                   n;
  logic [6:0]           offs[11] = '{7'h00, 7'h04, 7'h08, 7'h0c, 7'h1c, 7'h24, 7'h2c, 7'h34, 7'h40, 7'h44, 7'h10};
  scr_pkg::scr_tx_type  exp_k[5] = '{scr_pkg::TX_CPU, scr_pkg::TX_RSP, scr_pkg::TX_WB,
                                     scr_pkg::TX_WB, scr_pkg::TX_CPU};

  scr_responder scr_responder_inst (.SYS_CLK(sys_clk), .RST_N(rst_n), .NODE_ID(NODE), .REF(ref_bus),
    .REF_ACK(ref_ack), .REF_NACK(ref_nack), .IVI(ivi), .ERR(err), .HARD_ERR_IRQ(hard_err_irq),
    .WB_PEND(wb_pend), .CPU_PEND(cpu_pend), .TX_READY(tx_ready), .TX_VALID(tx_valid),
    .TX_KIND(tx_kind), .TX_DATA(tx_data));
  scr_node_model scr_node_model_inst (.SYS_CLK(sys_clk), .REF(ref_bus), .REF_ACK(ref_ack),
    .REF_NACK(ref_nack), .WB_PEND(wb_pend), .CPU_PEND(cpu_pend), .TX_READY(tx_ready),
    .TX_VALID(tx_valid), .TX_KIND(tx_kind), .TX_DATA(tx_data));

  // Compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Register read; the low address bits are free to vary
  task automatic rd(input scr_pkg::scr_cmd_type c, input logic [6:0] off, input logic [1:0] lo,
                    output logic [31:0] d);
    int k;
    k = scr_node_model_inst.rsp_cnt;
    scr_node_model_inst.xfer(c, {BASE[31:7], off[6:2], lo}, 32'h0, 1'b1, ack, nack);
    for (int i = 0; i < 100 && scr_node_model_inst.rsp_cnt == k; i++)
      @(posedge sys_clk);
    check("read response", 32'(scr_node_model_inst.rsp_cnt - k), 32'h1);
    d = scr_node_model_inst.last_rsp;
  endtask : rd

  // Register write with an empty byte mask
  task automatic wr(input logic [6:0] off, input logic [31:0] d);
    scr_node_model_inst.xfer(scr_pkg::CMD_WMASK, {BASE[31:7], off[6:2], 2'h3}, d, 1'b1, ack, nack);
    check("write ack", {31'h0, ack}, 32'h1);
  endtask : wr

  // Verdict and end of run
  task automatic end_of_test();
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // 100 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Watchdog
  initial
  begin
    #200us;
    failures++;
    end_of_test();
  end

  // Test sequence
  initial
  begin
    rst_n = 1'b0;
    ivi   = '0;
    err   = '0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    // Reset values and decode, low address bits cycling through 0 to 3
    foreach (offs[i])
    begin
      rd(scr_pkg::CMD_READ, offs[i], 2'(i), rdat);
      check("reset value", rdat, offs[i] == scr_pkg::OFF_DEV ? scr_pkg::DEV_TYPE_ID :
            offs[i] == scr_pkg::OFF_BCR ? scr_pkg::RST_BCR : scr_pkg::RST_WORD);
    end
    // Unlock write and interlocked read act plainly, whole word
    scr_node_model_inst.xfer(scr_pkg::CMD_UWMASK, BASE | 32'hf, 32'hdead_beef, 1'b1, ack, nack);
    rd(scr_pkg::CMD_IREAD, scr_pkg::OFF_GPR, 2'h1, rdat);
    check("general_purpose", rdat, 32'hdead_beef);
    wr(scr_pkg::OFF_NCSR, 32'h1234_5678);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_NCSR, 2'h3, rdat);
    check("node_control_status", rdat, 32'h1234_5678);
    // Read-only and unlisted places keep their value
    for (int j = 0; j < 3; j++)
    begin
      wr(offs[j * 2 + (j == 2 ? 6 : 0)], 32'hffff_ffff);
      rd(scr_pkg::CMD_READ, offs[j * 2 + (j == 2 ? 6 : 0)], 2'h0, rdat);
      check("read-only", rdat, j == 0 ? scr_pkg::DEV_TYPE_ID : 32'h0);
    end
    // Another node's window gets no answer
    scr_node_model_inst.xfer(scr_pkg::CMD_READ, BASE + (32'h1 << scr_pkg::NS_SHIFT), 32'h0, 1'b0, ack, nack);
    check("foreign answer", {30'h0, ack, nack}, 32'h0);
    // Own window above the register area: low bits alias the scratch register, which must stay untouched
    scr_node_model_inst.xfer(scr_pkg::CMD_WMASK, BASE | 32'h0004_008c, 32'h1111_1111, 1'b1, ack, nack);
    check("far offset ack", {31'h0, ack}, 32'h1);
    n = scr_node_model_inst.rsp_cnt;
    scr_node_model_inst.xfer(scr_pkg::CMD_READ, BASE | 32'h0004_008c, 32'h0, 1'b1, ack, nack);
    repeat (6) @(posedge sys_clk);
    check("far offset responses", 32'(scr_node_model_inst.rsp_cnt - n), 32'h1);
    check("far offset data", scr_node_model_inst.last_rsp, 32'h0);
    // Single slot: refused while the read waits on a slow bus
    scr_node_model_inst.stall = 6;
    n = scr_node_model_inst.rsp_cnt;
    scr_node_model_inst.xfer(scr_pkg::CMD_READ, BASE | 32'hc, 32'h0, 1'b1, ack, nack);
    scr_node_model_inst.xfer(scr_pkg::CMD_WMASK, BASE | 32'hc, 32'h0bad_0bad, 1'b0, ack, nack);
    check("nack", {31'h0, nack}, 32'h1);
    scr_node_model_inst.xfer(scr_pkg::CMD_WMASK, BASE | 32'hc, 32'h600d_f00d, 1'b1, ack, nack);
    check("retry ack", {31'h0, ack}, 32'h1);
    check("responses", 32'(scr_node_model_inst.rsp_cnt - n), 32'h1);
    check("queued read", scr_node_model_inst.last_rsp, 32'hdead_beef);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_GPR, 2'h2, rdat);
    check("general_purpose", rdat, 32'h600d_f00d);
    scr_node_model_inst.stall = 0;
    // Errors on both writeback queues, then a write-error interrupt
    @(posedge sys_clk);
    err <= '{1'b1, 1'b1, 1'b0, 32'ha000_0040, 32'h11, 32'hc3};
    @(posedge sys_clk);
    err <= '{1'b1, 1'b1, 1'b1, 32'hb000_0080, 32'h22, 32'hc4};
    @(posedge sys_clk);
    err <= '0;
    ivi <= '{1'b1, 1'b1, 16'h0004};
    @(posedge sys_clk);
    ivi <= '0;
    @(posedge sys_clk);
    check("hard_err_irq", {31'h0, hard_err_irq}, 32'h1);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_WF0, 2'h0, rdat);
    check("writeback0_failing_address", rdat, 32'ha000_0040);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_WF1, 2'h0, rdat);
    check("writeback1_failing_address", rdat, 32'hb000_0080);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_FADR, 2'h0, rdat);
    check("failing_address", rdat, 32'hb000_0080);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_FAER, 2'h0, rdat);
    check("failing_address_extension", rdat, 32'h0000_0022);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_BEER, 2'h0, rdat);
    check("bus_error_extension", rdat, 32'h0000_00c4);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_BER, 2'h0, rdat);
    check("bus_error", rdat & 32'h8800_0000, 32'h8800_0000);
    // Writing one clears the write-error flag and lets the interrupt drop
    wr(scr_pkg::OFF_BER, 32'h0800_0000);
    rd(scr_pkg::CMD_READ, scr_pkg::OFF_BER, 2'h0, rdat);
    check("bus_error cleared", rdat & 32'h8800_0000, 32'h8000_0000);
    check("hard_err_irq low", {31'h0, hard_err_irq}, 32'h0);
    // Response beats writeback beats processor; a stalled processor transfer lets both queue up
    scr_node_model_inst.kinds.delete();
    scr_node_model_inst.stall    = 3;
    scr_node_model_inst.CPU_PEND <= 1'b1;
    scr_node_model_inst.xfer(scr_pkg::CMD_READ, BASE | 32'hc, 32'h0, 1'b1, ack, nack);
    scr_node_model_inst.WB_PEND  <= 2'h1;
    for (int i = 0; i < 100 && scr_node_model_inst.kinds.size() < 3; i++)
      @(posedge sys_clk);
    // One quiet edge, so the model's own drop of the level is never overwritten in the same step
    @(posedge sys_clk);
    scr_node_model_inst.stall    = 0;
    scr_node_model_inst.WB_PEND  <= 2'h1;
    scr_node_model_inst.CPU_PEND <= 1'b1;
    for (int i = 0; i < 100 && scr_node_model_inst.kinds.size() < 5; i++)
      @(posedge sys_clk);
    foreach (exp_k[i])
      check("tx kind", {30'h0, scr_node_model_inst.kinds[i]}, {30'h0, exp_k[i]});
    end_of_test();
  end
endmodule : tb_top
